// ==== verilog/lmcfg_bank.sv ====
// configuration and fault-mask register bank of a 12-switch led bypass
// matrix manager, with link watchdog and receive-idle handling.
// assumes a decoded command port from the serial front end, status
// levels from the analog side and one 100 MHz clock.
// What this block does
// - 3-bit short thresholds, switches 5-8
// - switches 9-12 thresholds, reset zero, read/write
// - 4-bit watchdog duration, zero disables
// - no valid command for duration sets watchdog
// - watchdog asserts fault, applies timeout pattern
// - timeout pattern: bit per switch, 1 closed
// - cluster id resets 1, gates cluster writes
// - override bit holds that switch closed
// - led faults only evaluated while switch open
// - group A members follow group selector 0001
// - group B members follow group selector 0010
// - overheat action: 0 close all, 1 open all
// - general mask bits block fault sources
// - per-led mask blocks open and short faults
// - read-only resistor decode status bits
// - unmasked general status asserts fault pin
// - sixteen idle bit times flags receive timeout
`timescale 1ns/1ns
module lmcfg_bank #(
   parameter int BIT_CYCLES = 16'd868
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // decoded command port
   input wire logic CMD_VALID,
   input wire logic CMD_WRITE,
   input wire logic CMD_CLUSTER,
   input wire logic [5:0] CMD_CLUSTER_ID,
   input wire logic [7:0] CMD_ADDR,
   input wire logic [15:0] CMD_WDATA,
   output logic [15:0] READ_DATA,
   output logic READ_VALID,
   // link activity
   input wire logic RX_EDGE,
   input wire logic SWITCHING_ENABLE,
   // status from the rest of the device
   input wire logic [6:0] GEN_STATUS,
   input wire logic OVERHEAT_SHUTDOWN,
   input wire logic [11:0] DUTY_SWITCH_CLOSED,
   input wire logic [11:0] OPEN_DETECT,
   input wire logic [11:0] SHORT_DETECT,
   input wire logic [4:0] DECODE_STATUS,
   input wire logic [3:0] GROUP_SELECTOR,
   input wire logic GROUP_WRITE,
   // configuration outputs
   output logic [35:0] SHORT_THRESHOLD_CODE,
   output logic [5:0] CLUSTER_IDENTIFIER,
   output logic [11:0] SWITCH_CLOSED,
   output logic [11:0] OPEN_FAULT,
   output logic [11:0] SHORT_FAULT,
   output logic [11:0] GROUP_WRITE_HIT,
   output logic [11:0] FIRST_GROUP_MEMBERS,
   output logic [11:0] SECOND_GROUP_MEMBERS,
   output logic LINK_TIMEOUT,
   output logic RX_TIMEOUT,
   output logic FAULT_PIN_N
);
   logic [15:0] short_threshold_sw5_8;
   logic [15:0] short_threshold_sw9_12;
   logic [15:0] serial_link_config;
   logic [11:0] timeout_switch_pattern;
   logic [11:0] forced_closed_bits;
   logic [11:0] per_led_mask_bits;
   logic [6:0] gen_mask;
   logic overheat_switch_action;
   logic [4:0] decode_stat;
   logic accept;
   logic wr;
   logic fault_req;
   logic [11:0] next_closed;
   logic [15:0] next_rdata;

   lmcfg_ctl_if ctl ();

   // ==========================================================
   // command acceptance
   always_comb begin
      // cluster call only when the id matches the stored one
      accept = CMD_VALID &&
         (!CMD_CLUSTER || CMD_CLUSTER_ID ==
            serial_link_config[lmcfg_pkg::CID_W-1:0]);
      wr = accept && CMD_WRITE;
   end

   assign ctl.wd_code =
      serial_link_config[lmcfg_pkg::WD_LSB +: lmcfg_pkg::WD_W];
   assign ctl.cmd_ok = accept;
   assign ctl.rx_edge = RX_EDGE;
   assign ctl.bit_cycles = 16'(BIT_CYCLES);

   lmcfg_timeouts u_timeouts (
      .clk(CLK_SYS),
      .rst(RST),
      .ctl(ctl)
   );

   // ==========================================================
   // configuration registers
   // switching enable should be low while these change; the bank
   // stores regardless, downstream logic owns that restriction
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         short_threshold_sw5_8 <= lmcfg_pkg::RST_THR;
         short_threshold_sw9_12 <= lmcfg_pkg::RST_THR;
         serial_link_config <= lmcfg_pkg::RST_LINK_CFG;
         timeout_switch_pattern <= lmcfg_pkg::RST_CFG12[11:0];
         forced_closed_bits <= lmcfg_pkg::RST_CFG12[11:0];
         FIRST_GROUP_MEMBERS <= lmcfg_pkg::RST_CFG12[11:0];
         SECOND_GROUP_MEMBERS <= lmcfg_pkg::RST_CFG12[11:0];
         gen_mask <= lmcfg_pkg::RST_GEN_MASK[6:0];
         overheat_switch_action <= 1'b0;
         per_led_mask_bits <= lmcfg_pkg::RST_CFG12[11:0];
      end else if (wr) begin
         case (CMD_ADDR)
            lmcfg_pkg::ADDR_THR_SW5_8: begin
               short_threshold_sw5_8 <= {4'h0, CMD_WDATA[11:0]};
            end
            lmcfg_pkg::ADDR_THR_SW9_12: begin
               short_threshold_sw9_12 <= {4'h0, CMD_WDATA[11:0]};
            end
            lmcfg_pkg::ADDR_LINK_CFG: begin
               serial_link_config <= {6'h00, CMD_WDATA[9:0]};
            end
            lmcfg_pkg::ADDR_TIMEOUT_STATE: begin
               timeout_switch_pattern <= CMD_WDATA[11:0];
            end
            lmcfg_pkg::ADDR_FORCED_CLOSED: begin
               forced_closed_bits <= CMD_WDATA[11:0];
            end
            lmcfg_pkg::ADDR_GROUP_A: begin
               FIRST_GROUP_MEMBERS <= CMD_WDATA[11:0];
            end
            lmcfg_pkg::ADDR_GROUP_B: begin
               SECOND_GROUP_MEMBERS <= CMD_WDATA[11:0];
            end
            lmcfg_pkg::ADDR_GEN_MASK: begin
               gen_mask <= CMD_WDATA[6:0];
               overheat_switch_action <= CMD_WDATA[lmcfg_pkg::ACT_BIT];
            end
            lmcfg_pkg::ADDR_LED_MASK: begin
               per_led_mask_bits <= CMD_WDATA[11:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // timeout status: the fire pulse wins over a clearing command
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         LINK_TIMEOUT <= 1'b0;
         RX_TIMEOUT <= 1'b0;
      end else begin
         if (ctl.wd_fire) begin
            LINK_TIMEOUT <= 1'b1;
         end else if (accept) begin
            LINK_TIMEOUT <= 1'b0;
         end
         if (ctl.rx_fire) begin
            RX_TIMEOUT <= 1'b1;
         end else if (RX_EDGE) begin
            RX_TIMEOUT <= 1'b0;
         end
      end
   end

   // ==========================================================
   // switch state priority: overheat, timeout, override, duty
   always_comb begin
      next_closed = DUTY_SWITCH_CLOSED | forced_closed_bits;
      if (!SWITCHING_ENABLE) begin
         next_closed = '1;
      end
      if (LINK_TIMEOUT || RX_TIMEOUT) begin
         next_closed = timeout_switch_pattern;
      end
      if (OVERHEAT_SHUTDOWN) begin
         next_closed = overheat_switch_action ? '0 : '1;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         SWITCH_CLOSED <= '1;
      end else begin
         SWITCH_CLOSED <= next_closed;
      end
   end

   // ==========================================================
   // led faults qualified by open switch
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         OPEN_FAULT <= '0;
         SHORT_FAULT <= '0;
      end else begin
         OPEN_FAULT <= OPEN_DETECT & ~SWITCH_CLOSED;
         SHORT_FAULT <= SHORT_DETECT & ~SWITCH_CLOSED;
      end
   end

   // ==========================================================
   // group write targeting
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         GROUP_WRITE_HIT <= '0;
      end else if (!GROUP_WRITE) begin
         GROUP_WRITE_HIT <= '0;
      end else if (GROUP_SELECTOR == lmcfg_pkg::GROUP_SEL_A) begin
         GROUP_WRITE_HIT <= FIRST_GROUP_MEMBERS;
      end else if (GROUP_SELECTOR == lmcfg_pkg::GROUP_SEL_B) begin
         GROUP_WRITE_HIT <= SECOND_GROUP_MEMBERS;
      end else begin
         GROUP_WRITE_HIT <= '0;
      end
   end

   // ==========================================================
   // fault pin, active low
   lmcfg_fault_gate u_fault (
      .gen_status(GEN_STATUS),
      .open_flags(OPEN_FAULT),
      .short_flags(SHORT_FAULT),
      .led_mask(per_led_mask_bits),
      .gen_mask(gen_mask),
      .link_timeout(LINK_TIMEOUT),
      .fault_req(fault_req)
   );

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         FAULT_PIN_N <= 1'b1;
      end else begin
         FAULT_PIN_N <= !fault_req;
      end
   end

   // ==========================================================
   // decode status capture and read port
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         decode_stat <= 5'h00;
      end else begin
         decode_stat <= DECODE_STATUS;
      end
   end

   always_comb begin
      next_rdata = 16'h0000;
      case (CMD_ADDR)
         lmcfg_pkg::ADDR_THR_SW5_8: next_rdata = short_threshold_sw5_8;
         lmcfg_pkg::ADDR_THR_SW9_12: next_rdata = short_threshold_sw9_12;
         lmcfg_pkg::ADDR_LINK_CFG: next_rdata = serial_link_config;
         lmcfg_pkg::ADDR_TIMEOUT_STATE:
            next_rdata = {4'h0, timeout_switch_pattern};
         lmcfg_pkg::ADDR_FORCED_CLOSED:
            next_rdata = {4'h0, forced_closed_bits};
         lmcfg_pkg::ADDR_GROUP_A: next_rdata = {4'h0, FIRST_GROUP_MEMBERS};
         lmcfg_pkg::ADDR_GROUP_B:
            next_rdata = {4'h0, SECOND_GROUP_MEMBERS};
         lmcfg_pkg::ADDR_GEN_MASK:
            next_rdata = {3'h0, overheat_switch_action, 5'h00, gen_mask};
         lmcfg_pkg::ADDR_LED_MASK: next_rdata = {4'h0, per_led_mask_bits};
         lmcfg_pkg::ADDR_DECODE_STAT:
            next_rdata = {11'h000, decode_stat};
         default: next_rdata = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         READ_DATA <= 16'h0000;
         READ_VALID <= 1'b0;
      end else begin
         READ_VALID <= accept && !CMD_WRITE;
         if (accept && !CMD_WRITE) begin
            READ_DATA <= next_rdata;
         end
      end
   end

   // ==========================================================
   // registered copies of configuration fields
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         SHORT_THRESHOLD_CODE <= '0;
         CLUSTER_IDENTIFIER <= lmcfg_pkg::RST_LINK_CFG[5:0];
      end else begin
         SHORT_THRESHOLD_CODE <= {short_threshold_sw9_12[11:0],
            short_threshold_sw5_8[11:0], 12'h000};
         CLUSTER_IDENTIFIER <= serial_link_config[5:0];
      end
   end
endmodule : lmcfg_bank

// ==== verilog/lmcfg_pkg.sv ====
// register map, field positions, reset values and timing counts of the
// led matrix configuration and fault-mask bank.
// assumes a 100 MHz system clock and 16-bit register words.
package lmcfg_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_THR_SW5_8 = 8'h05;
   localparam logic [7:0] ADDR_THR_SW9_12 = 8'h06;
   localparam logic [7:0] ADDR_LINK_CFG = 8'h07;
   localparam logic [7:0] ADDR_TIMEOUT_STATE = 8'h08;
   localparam logic [7:0] ADDR_FORCED_CLOSED = 8'h09;
   localparam logic [7:0] ADDR_GROUP_A = 8'h0a;
   localparam logic [7:0] ADDR_GROUP_B = 8'h0b;
   localparam logic [7:0] ADDR_GEN_MASK = 8'h0c;
   localparam logic [7:0] ADDR_LED_MASK = 8'h0d;
   localparam logic [7:0] ADDR_DECODE_STAT = 8'h0e;
   // ==========================================================
   // field positions and widths
   localparam int NUM_SW = 12;
   localparam int THR_W = 3;
   localparam int CID_LSB = 0;
   localparam int CID_W = 6;
   localparam int WD_LSB = 6;
   localparam int WD_W = 4;
   localparam int ACT_BIT = 12;
   localparam int GEN_MASK_W = 7;
   localparam int MSK_LINK_ERR = 6;
   localparam int MSK_TRACE = 5;
   localparam int MSK_OPEN = 4;
   localparam int MSK_SHORT = 3;
   localparam int MSK_PUMP = 2;
   localparam int MSK_DECODE = 1;
   localparam int MSK_WARN = 0;
   localparam int DEC_DONE = 4;
   localparam int DEC_ADDR_OVER = 3;
   localparam int DEC_GRADE_OVER = 2;
   localparam int DEC_ADDR_UNDER = 1;
   localparam int DEC_GRADE_UNDER = 0;
   // ==========================================================
   // reset values and group selector codes
   localparam logic [15:0] RST_THR = 16'h0000;
   localparam logic [15:0] RST_LINK_CFG = 16'h0001;
   localparam logic [15:0] RST_CFG12 = 16'h0000;
   localparam logic [15:0] RST_GEN_MASK = 16'h0000;
   localparam logic [3:0] GROUP_SEL_A = 4'h1;
   localparam logic [3:0] GROUP_SEL_B = 4'h2;
   // ==========================================================
   // timing: watchdog durations in microseconds, clock in MHz
   localparam int CLK_MHZ = 100;
   localparam int RX_TIMEOUT_BITS = 16;
   typedef int unsigned lmcfg_us_type;
   localparam lmcfg_us_type WD_US [16] = '{
      0, 200, 500, 1000, 2000, 5000, 10000, 20000, 50000, 100000,
      200000, 500000, 1000000, 2000000, 5000000, 5000000};
   // cycles per microsecond step; counts up to 500,000,000 fit 32 bits
   localparam int unsigned WD_CYC_PER_US = CLK_MHZ;
endpackage : lmcfg_pkg

// ==== verilog/lmcfg_ctl_if.sv ====
// carrier between the register bank and its timeout engine.
// assumes both ends on CLK_SYS.
`timescale 1ns/1ns
interface lmcfg_ctl_if;
   logic [3:0] wd_code;
   logic cmd_ok;
   logic rx_edge;
   logic [15:0] bit_cycles;
   logic wd_fire;
   logic rx_fire;
   modport bank (output wd_code, cmd_ok, rx_edge, bit_cycles,
      input wd_fire, rx_fire);
   modport timer (input wd_code, cmd_ok, rx_edge, bit_cycles,
      output wd_fire, rx_fire);
endinterface : lmcfg_ctl_if

// ==== verilog/lmcfg_timeouts.sv ====
// link watchdog and receive-idle timers.
// assumes cmd_ok pulses once per valid command and rx_edge per line edge.
`timescale 1ns/1ns
module lmcfg_timeouts (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control carrier
   lmcfg_ctl_if.timer ctl
);
   logic [31:0] wd_count;
   logic [31:0] wd_limit;
   logic [19:0] idle_count;
   logic [19:0] idle_limit;

   // ==========================================================
   // watchdog: fires once when the selected duration elapses
   always_comb begin
      wd_limit = lmcfg_pkg::WD_US[ctl.wd_code] *
         lmcfg_pkg::WD_CYC_PER_US;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_count <= 32'h00000000;
         ctl.wd_fire <= 1'b0;
      end else begin
         ctl.wd_fire <= 1'b0;
         if (ctl.cmd_ok || ctl.wd_code == 4'h0) begin
            wd_count <= 32'h00000000;
         end else if (wd_count < wd_limit) begin
            wd_count <= wd_count + 32'h00000001;
            if (wd_count + 32'h00000001 == wd_limit) begin
               ctl.wd_fire <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // receive idle: more than sixteen bit times without an edge
   always_comb begin
      idle_limit = 20'(ctl.bit_cycles) *
         20'(lmcfg_pkg::RX_TIMEOUT_BITS);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idle_count <= 20'h00000;
         ctl.rx_fire <= 1'b0;
      end else begin
         ctl.rx_fire <= 1'b0;
         if (ctl.rx_edge) begin
            idle_count <= 20'h00000;
         end else if (idle_count <= idle_limit) begin
            idle_count <= idle_count + 20'h00001;
            if (idle_count == idle_limit) begin
               ctl.rx_fire <= 1'b1;
            end
         end
      end
   end
endmodule : lmcfg_timeouts

// ==== verilog/lmcfg_fault_gate.sv ====
// combines general status and per-led faults into the fault request.
// assumes status inputs are already registered.
`timescale 1ns/1ns
module lmcfg_fault_gate (
   // status in
   input wire logic [6:0] gen_status,
   input wire logic [11:0] open_flags,
   input wire logic [11:0] short_flags,
   input wire logic [11:0] led_mask,
   input wire logic [6:0] gen_mask,
   input wire logic link_timeout,
   // result
   output logic fault_req
);
   logic [6:0] eff;
   always_comb begin
      eff = gen_status;
      // per-led mask removes individual leds before the summary
      eff[lmcfg_pkg::MSK_OPEN] = |(open_flags & ~led_mask);
      eff[lmcfg_pkg::MSK_SHORT] = |(short_flags & ~led_mask);
      fault_req = |(eff & ~gen_mask) || link_timeout;
   end
endmodule : lmcfg_fault_gate

// ==== tb/lmcfg_bank_asserts.sv ====
// port-level checker for the configuration and fault-mask bank.
// assumes it is bound to lmcfg_bank and sees only its ports.
`timescale 1ns/1ns
module lmcfg_bank_asserts #(
   parameter int BIT_CYCLES = 16'd868
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // command port
   input wire logic CMD_VALID,
   input wire logic CMD_WRITE,
   input wire logic CMD_CLUSTER,
   input wire logic [5:0] CMD_CLUSTER_ID,
   input wire logic [7:0] CMD_ADDR,
   input wire logic [15:0] READ_DATA,
   input wire logic READ_VALID,
   // activity and status
   input wire logic RX_EDGE,
   input wire logic SWITCHING_ENABLE,
   input wire logic OVERHEAT_SHUTDOWN,
   input wire logic [11:0] DUTY_SWITCH_CLOSED,
   input wire logic [11:0] OPEN_DETECT,
   input wire logic [3:0] GROUP_SELECTOR,
   input wire logic GROUP_WRITE,
   // outputs watched
   input wire logic [35:0] SHORT_THRESHOLD_CODE,
   input wire logic [5:0] CLUSTER_IDENTIFIER,
   input wire logic [11:0] SWITCH_CLOSED,
   input wire logic [11:0] OPEN_FAULT,
   input wire logic [11:0] GROUP_WRITE_HIT,
   input wire logic [11:0] FIRST_GROUP_MEMBERS,
   input wire logic [11:0] SECOND_GROUP_MEMBERS,
   input wire logic LINK_TIMEOUT,
   input wire logic RX_TIMEOUT,
   input wire logic FAULT_PIN_N
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // cycles since the last line edge, saturating
   int idle;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST)
         idle <= 0;
      else if (RX_EDGE)
         idle <= 0;
      else if (idle < 100000)
         idle <= idle + 1;
   end
   property p_read_answer;
      CMD_VALID && !CMD_WRITE &&
      (!CMD_CLUSTER || CMD_CLUSTER_ID == CLUSTER_IDENTIFIER) |=> READ_VALID;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered");
   property p_cluster_refuse;
      CMD_VALID && CMD_CLUSTER && CMD_CLUSTER_ID != CLUSTER_IDENTIFIER
      |=> !READ_VALID;
   endproperty
   a_cluster_refuse: assert property (p_cluster_refuse)
      else $error("foreign cluster answered");
   property p_thr_lo;
      READ_VALID && $past(CMD_ADDR) == lmcfg_pkg::ADDR_THR_SW5_8
      |-> READ_DATA == {4'h0, SHORT_THRESHOLD_CODE[23:12]};
   endproperty
   a_thr_lo: assert property (p_thr_lo)
      else $error("thr 5-8 readback");
   property p_thr_hi;
      READ_VALID && $past(CMD_ADDR) == lmcfg_pkg::ADDR_THR_SW9_12
      |-> READ_DATA == {4'h0, SHORT_THRESHOLD_CODE[35:24]};
   endproperty
   a_thr_hi: assert property (p_thr_hi)
      else $error("thr 9-12 readback");
   property p_wd_fault;
      LINK_TIMEOUT |=> !FAULT_PIN_N;
   endproperty
   a_wd_fault: assert property (p_wd_fault)
      else $error("no fault on watchdog");
   property p_duty_pass;
      !OVERHEAT_SHUTDOWN && !LINK_TIMEOUT && !RX_TIMEOUT && SWITCHING_ENABLE
      |=> (SWITCH_CLOSED & $past(DUTY_SWITCH_CLOSED)) ==
      $past(DUTY_SWITCH_CLOSED);
   endproperty
   a_duty_pass: assert property (p_duty_pass)
      else $error("duty switch open");
   property p_heat;
      OVERHEAT_SHUTDOWN |=> SWITCH_CLOSED == 12'h000 ||
      SWITCH_CLOSED == 12'hfff;
   endproperty
   a_heat: assert property (p_heat)
      else $error("mixed switches");
   property p_open_eval;
      1'b1 |=> OPEN_FAULT == ($past(OPEN_DETECT) & ~$past(SWITCH_CLOSED));
   endproperty
   a_open_eval: assert property (p_open_eval)
      else $error("open fault on closed");
   property p_grp_a;
      GROUP_WRITE && GROUP_SELECTOR == lmcfg_pkg::GROUP_SEL_A
      |=> GROUP_WRITE_HIT == $past(FIRST_GROUP_MEMBERS);
   endproperty
   a_grp_a: assert property (p_grp_a)
      else $error("group a hit");
   property p_grp_b;
      GROUP_WRITE && GROUP_SELECTOR == lmcfg_pkg::GROUP_SEL_B
      |=> GROUP_WRITE_HIT == $past(SECOND_GROUP_MEMBERS);
   endproperty
   a_grp_b: assert property (p_grp_b)
      else $error("group b hit");
   property p_rx_early;
      RX_TIMEOUT |-> idle >= 16 * BIT_CYCLES || $past(RX_EDGE);
   endproperty
   a_rx_early: assert property (p_rx_early)
      else $error("rx timeout early");
   property p_rx_late;
      idle > 16 * BIT_CYCLES + 3 |-> RX_TIMEOUT;
   endproperty
   a_rx_late: assert property (p_rx_late)
      else $error("rx timeout missing");
endmodule : lmcfg_bank_asserts

bind lmcfg_bank lmcfg_bank_asserts #(.BIT_CYCLES(BIT_CYCLES)) i_chk (.*);

// ==== tb/lmcfg_host_model.sv ====
// host side of the link: issues decoded commands and line activity.
// assumes the bank samples commands on the rising clock edge.
`timescale 1ns/1ns
module lmcfg_host_model (
   // clock and requests from the bench
   input wire logic clk,
   input wire logic rx_live,
   input wire logic sw_enable,
   // command port toward the bank
   output logic cmd_valid,
   output logic cmd_write,
   output logic cmd_cluster,
   output logic [5:0] cmd_cluster_id,
   output logic [7:0] cmd_addr,
   output logic [15:0] cmd_wdata,
   output logic rx_edge,
   output logic switching_enable
);
   int tick = 0;
   logic quiet = 1'b0;
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_cluster = 1'b0;
      cmd_cluster_id = 6'h00;
      cmd_addr = 8'h00;
      cmd_wdata = 16'h0000;
      rx_edge = 1'b0;
   end
   assign switching_enable = sw_enable && !quiet;
   // the line toggles every eighth clock while rx_live is high, whether or not commands are sent
   always @(posedge clk) begin
      tick <= tick + 1;
      rx_edge <= #1 rx_live && tick[2:0] == 3'h0;
   end
   task automatic send(input logic cl, input logic [5:0] id,
         input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 quiet = wr;
      @(posedge clk);
      #1 cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_cluster = cl;
      cmd_cluster_id = id;
      cmd_addr = a;
      cmd_wdata = d;
      @(posedge clk);
      // released address, data and id show garbage, not the last value
      #1 cmd_valid = 1'b0;
      cmd_addr = ~a;
      cmd_wdata = ~d;
      cmd_cluster_id = ~id;
      quiet = 1'b0;
   endtask : send
endmodule : lmcfg_host_model

// ==== tb/lmcfg_bank_tb.sv ====
// self-checking bench for the configuration and fault-mask bank.
// assumes BIT_CYCLES 4 and a 100 MHz clock.
`timescale 1ns/1ns
module lmcfg_bank_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic rx_live = 1'b1, sw_en = 1'b1, overheat = 1'b0, grp_wr = 1'b0;
   logic [6:0] gen_status = 7'h00;
   logic [11:0] duty = 12'h000, open_det = 12'h000, short_det = 12'h000;
   logic [4:0] decode = 5'h00;
   logic [3:0] grp_sel = 4'h0;
   logic cmd_valid, cmd_write, cmd_cluster, rx_edge, switching_enable;
   logic [5:0] cmd_cid, cluster_identifier;
   logic [7:0] cmd_addr;
   logic [15:0] cmd_wdata, read_data, d;
   logic read_valid, link_to, rx_to, fault_n;
   logic [35:0] thr;
   logic [11:0] sw_closed, open_flt, short_flt, hit, grp_a, grp_b;
   int mismatches = 0, samples_checked = 0, n;
   logic [15:0] wmask [10] = '{16'h0fff, 16'h0fff, 16'h03ff, 16'h0fff,
      16'h0fff, 16'h0fff, 16'h0fff, 16'h107f, 16'h0fff, 16'h0000};
   always #5 clk_sys = ~clk_sys;
   lmcfg_host_model i_host (.clk(clk_sys), .rx_live(rx_live),
      .sw_enable(sw_en), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_cluster(cmd_cluster), .cmd_cluster_id(cmd_cid),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rx_edge(rx_edge),
      .switching_enable(switching_enable));
   lmcfg_bank #(.BIT_CYCLES(4)) i_dut (.CLK_SYS(clk_sys), .RST(rst),
      .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
      .CMD_CLUSTER(cmd_cluster), .CMD_CLUSTER_ID(cmd_cid),
      .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .READ_DATA(read_data),
      .READ_VALID(read_valid), .RX_EDGE(rx_edge),
      .SWITCHING_ENABLE(switching_enable), .GEN_STATUS(gen_status),
      .OVERHEAT_SHUTDOWN(overheat), .DUTY_SWITCH_CLOSED(duty),
      .OPEN_DETECT(open_det), .SHORT_DETECT(short_det),
      .DECODE_STATUS(decode), .GROUP_SELECTOR(grp_sel),
      .GROUP_WRITE(grp_wr), .SHORT_THRESHOLD_CODE(thr),
      .CLUSTER_IDENTIFIER(cluster_identifier), .SWITCH_CLOSED(sw_closed),
      .OPEN_FAULT(open_flt), .SHORT_FAULT(short_flt), .GROUP_WRITE_HIT(hit),
      .FIRST_GROUP_MEMBERS(grp_a), .SECOND_GROUP_MEMBERS(grp_b),
      .LINK_TIMEOUT(link_to), .RX_TIMEOUT(rx_to), .FAULT_PIN_N(fault_n));
   // ==========================================================
   // shared tasks
   task automatic finish_test();
      if (mismatches == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      i_host.send(1'b0, 6'h00, 1'b1, a, v);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      int k;
      i_host.send(1'b0, 6'h00, 1'b0, a, 16'h0000);
      for (k = 0; k < 4 && read_valid !== 1'b1; k++)
         cyc(1);
      if (k == 4) begin
         check(1'b0, 1'b1);
         finish_test();
      end
      v = read_data;
   endtask : rd
   task automatic do_reset();
      #1 rst = 1'b1;
      cyc(8);
      rst = 1'b0;
   endtask : do_reset
   // ==========================================================
   // main sequence
   initial begin
      do_reset();
      for (int i = 0; i < 10; i++) begin
         rd(8'h05 + 8'(i), d);
         check(d, (i == 2) ? 16'h0001 : 16'h0000);
         wr(8'h05 + 8'(i), 16'hffff);
         rd(8'h05 + 8'(i), d);
         check(d, wmask[i]);
      end
      wr(8'h20, 16'hffff);
      rd(8'h20, d);
      check(d, 16'h0000);
      decode = 5'h15;
      rd(8'h0e, d);
      check(d, 16'h0015);
      do_reset();
      for (int c = 0; c < 8; c++) begin
         wr(8'h05, {4'h0, {4{3'(c)}}});
         wr(8'h06, {4'h0, {4{~3'(c)}}});
         cyc(1);
         check(thr, {{4{~3'(c)}}, {4{3'(c)}}, 12'h000});
      end
      i_host.send(1'b1, 6'h02, 1'b0, 8'h07, 16'h0000);
      check(read_valid, 1'b0);
      i_host.send(1'b1, 6'h02, 1'b1, 8'h09, 16'h000f);
      rd(8'h09, d);
      check(d, 16'h0000);
      i_host.send(1'b1, 6'h01, 1'b1, 8'h09, 16'h000f);
      duty = 12'h0f0;
      open_det = 12'hfff;
      short_det = 12'hfff;
      cyc(4);
      check(sw_closed, 12'h0ff);
      check(open_flt, 12'hf00);
      check(short_flt, 12'hf00);
      check(fault_n, 1'b0);
      wr(8'h0d, 16'h0f00);
      cyc(4);
      check(fault_n, 1'b1);
      wr(8'h0d, 16'h0000);
      open_det = 12'h000;
      short_det = 12'h000;
      for (int b = 0; b < 7; b++) begin
         gen_status = 7'h01 << b;
         open_det = (b == 4) ? 12'hfff : 12'h000;
         short_det = (b == 3) ? 12'hfff : 12'h000;
         cyc(4);
         check(fault_n, 1'b0);
         wr(8'h0c, 16'h0001 << b);
         cyc(4);
         check(fault_n, 1'b1);
         wr(8'h0c, 16'h0000);
      end
      gen_status = 7'h00;
      open_det = 12'h000;
      short_det = 12'h000;
      overheat = 1'b1;
      cyc(3);
      check(sw_closed, 12'hfff);
      wr(8'h0c, 16'h1000);
      cyc(3);
      check(sw_closed, 12'h000);
      overheat = 1'b0;
      wr(8'h0a, 16'h000f);
      wr(8'h0b, 16'h00f0);
      for (int s = 0; s < 4; s++) begin
         grp_sel = 4'(s);
         grp_wr = 1'b1;
         cyc(1);
         check(hit, s == 1 ? 12'h00f : s == 2 ? 12'h0f0 : 12'h000);
         grp_wr = 1'b0;
         cyc(1);
      end
      wr(8'h08, 16'h0a5c);
      rx_live = 1'b0;
      cyc(56);
      check(rx_to, 1'b0);
      cyc(14);
      check(rx_to, 1'b1);
      check(sw_closed, 12'ha5c);
      rx_live = 1'b1;
      cyc(12);
      check(rx_to, 1'b0);
      wr(8'h07, 16'h0041);
      cyc(19990);
      check(link_to, 1'b0);
      for (n = 0; n < 20 && link_to !== 1'b1; n++)
         cyc(1);
      check(link_to, 1'b1);
      if (n == 20)
         finish_test();
      cyc(2);
      check(fault_n, 1'b0);
      check(sw_closed, 12'ha5c);
      rd(8'h07, d);
      cyc(2);
      check(link_to, 1'b0);
      finish_test();
   end
endmodule : lmcfg_bank_tb
